// ### bench/direct_address_move_decoder_test.sv
// Purpose: self-checking bench for the direct-address move decoder
// Assumes: bench plays the memory and the core's pointer writes
// Notes:   expectations come from opcode, field and pointer values
`timescale 1ns/1ps

module direct_address_move_decoder_test;
   logic        clk;
   logic        rst;
   logic        instr_valid;
   logic [15:0] instr;
   logic        instr_ready;
   logic        reg_wr_en;
   logic        reg_wr_sp;
   logic [31:0] reg_wdata;
   logic        mem_req;
   logic        mem_we;
   logic [31:0] mem_addr;
   logic [1:0]  mem_size;
   logic [31:0] mem_wdata;
   logic        mem_ack;
   logic [31:0] mem_rdata;
   logic [31:0] direct_pointer_reg;
   logic [31:0] stack_pointer_reg;
   logic        done;
   logic        unsupported_op;
   logic [1:0]  cycle_class;
   int          mismatches;
   int          total_checks;
   int          cycles = 0;

   direct_address_move_decoder dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
      .instr_ready(instr_ready), .reg_wr_en(reg_wr_en), .reg_wr_sp(reg_wr_sp), .reg_wdata(reg_wdata),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .direct_pointer_reg(direct_pointer_reg),
      .stack_pointer_reg(stack_pointer_reg), .done(done), .unsupported_op(unsupported_op),
      .cycle_class(cycle_class));

   always #2 clk = ~clk;

   // a hang costs one mismatch and still ends in the verdict
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick

   function automatic logic [31:0] size_mask(input logic [1:0] sz);
      return (sz == 2'h0) ? 32'h0000_00FF : (sz == 2'h1) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
   endfunction : size_mask

   task automatic setreg(input logic sp, input logic [31:0] val);
      reg_wr_en = 1'b1;
      reg_wr_sp = sp;
      reg_wdata = val;
      tick();
      reg_wr_en = 1'b0;
      check(sp ? stack_pointer_reg : direct_pointer_reg, val);
   endtask : setreg

   task automatic issue(input logic [7:0] op, input logic [7:0] fld);
      int n;
      n = 0;
      while (instr_ready !== 1'b1 && n < 50) begin
         tick();
         n++;
      end
      check({31'h0, instr_ready}, 32'h1);
      instr = {op, fld};
      instr_valid = 1'b1;
      tick();
      instr_valid = 1'b0;
   endtask : issue

   // answers one access after dly stalled cycles; released data is inverted
   // a call right after another needs dly 1, so mem_ack drops for an edge
   task automatic serve(input logic we, input logic [31:0] addr, input logic [1:0] sz,
                        input logic [31:0] wdata, input logic [31:0] rdata, input int dly);
      int n;
      n = 0;
      while (mem_req !== 1'b1 && n < 50) begin
         tick();
         n++;
      end
      repeat (dly) tick();
      check({31'h0, mem_req}, 32'h1);
      check({31'h0, mem_we}, {31'h0, we});
      check(mem_addr, addr);
      check({30'h0, mem_size}, {30'h0, sz});
      if (we) check(mem_wdata & size_mask(sz), wdata);
      check({31'h0, instr_ready}, 32'h0);
      mem_rdata = rdata;
      mem_ack = 1'b1;
      tick();
      mem_ack = 1'b0;
      mem_rdata = ~rdata;
   endtask : serve

   task automatic finish(input logic [1:0] cls);
      int n;
      n = 0;
      while (done !== 1'b1 && n < 50) begin
         tick();
         n++;
      end
      check({31'h0, done}, 32'h1);
      check({30'h0, cycle_class}, {30'h0, cls});
      check({31'h0, instr_ready}, 32'h1);
   endtask : finish

   task automatic test_reset();
      repeat (6) tick();
      check({26'h0, mem_req, done, unsupported_op, instr_ready, cycle_class}, 32'h0);
      check(direct_pointer_reg, 32'h0);
      check(stack_pointer_reg, 32'h0);
      rst = 1'b0;
      tick();
      check({31'h0, instr_ready}, 32'h1);
      $display("test_reset finished");
   endtask : test_reset

   task automatic test_word_direct();
      setreg(1'b0, 32'h1234_5678);
      issue(8'h08, 8'hFF);
      serve(1'b0, 32'h0000_03FC, 2'h2, 32'h0, 32'hCAFE_0001, 0);
      finish(2'h2);
      check(direct_pointer_reg, 32'hCAFE_0001);
      issue(8'h18, 8'h81);
      serve(1'b1, 32'h0000_0204, 2'h2, 32'hCAFE_0001, 32'h0, 2);
      finish(2'h1);
      $display("test_word_direct finished");
   endtask : test_word_direct

   task automatic test_ptr_moves();
      logic [7:0]  ops [6] = '{8'h0C, 8'h1C, 8'h0D, 8'h1D, 8'h0E, 8'h1E};
      logic [1:0]  sz;
      logic [31:0] p;
      logic [31:0] da;
      logic [31:0] d;
      setreg(1'b0, 32'h0000_1000);
      for (int i = 0; i < 6; i++) begin
         sz = 2'(2 - i / 2);
         da = {24'h0, 8'h80 | 8'(i)} << sz;
         p = direct_pointer_reg;
         d = 32'hA5C3_9E10 + 32'(i);
         issue(ops[i], 8'h80 | 8'(i));
         if (ops[i][4] == 1'b0) begin
            serve(1'b0, da, sz, 32'h0, d, i % 3);
            serve(1'b1, p, sz, d & size_mask(sz), 32'h0, 1);
         end else begin
            serve(1'b0, p, sz, 32'h0, d, i % 3);
            serve(1'b1, da, sz, d & size_mask(sz), 32'h0, 1);
         end
         finish(2'h1);
         check(direct_pointer_reg, p + (32'h1 << sz));
      end
      $display("test_ptr_moves finished");
   endtask : test_ptr_moves

   task automatic test_narrow_direct();
      setreg(1'b0, 32'h8765_4321);
      issue(8'h09, 8'h7F);
      serve(1'b0, 32'h0000_00FE, 2'h1, 32'h0, 32'hFFFF_B00C, 0);
      finish(2'h2);
      check(direct_pointer_reg, 32'h0000_B00C);
      issue(8'h19, 8'h7F);
      serve(1'b1, 32'h0000_00FE, 2'h1, 32'h0000_B00C, 32'h0, 1);
      finish(2'h1);
      issue(8'h0A, 8'hFF);
      serve(1'b0, 32'h0000_00FF, 2'h0, 32'h0, 32'h1234_56E7, 0);
      finish(2'h2);
      check(direct_pointer_reg, 32'h0000_00E7);
      issue(8'h1A, 8'h01);
      serve(1'b1, 32'h0000_0001, 2'h0, 32'h0000_00E7, 32'h0, 0);
      finish(2'h1);
      $display("test_narrow_direct finished");
   endtask : test_narrow_direct

   task automatic test_stack();
      setreg(1'b1, 32'h0000_0100);
      issue(8'h0B, 8'h10);
      check(stack_pointer_reg, 32'h0000_00FC);
      serve(1'b0, 32'h0000_0040, 2'h2, 32'h0, 32'h55AA_33CC, 0);
      serve(1'b1, 32'h0000_00FC, 2'h2, 32'h55AA_33CC, 32'h0, 1);
      finish(2'h1);
      issue(8'h1B, 8'h11);
      serve(1'b0, 32'h0000_00FC, 2'h2, 32'h0, 32'h0F0F_1234, 1);
      serve(1'b1, 32'h0000_0044, 2'h2, 32'h0F0F_1234, 32'h0, 1);
      finish(2'h1);
      check(stack_pointer_reg, 32'h0000_0100);
      $display("test_stack finished");
   endtask : test_stack

   task automatic test_unsupported();
      logic [15:0] ops [7] = '{16'hBC00, 16'hBD05, 16'h9FC0, 16'h9FD1, 16'h9FE2, 16'h9FF3, 16'h9FA0};
      logic        seen;
      logic        req;
      for (int i = 0; i < 7; i++) begin
         seen = 1'b0;
         req = 1'b0;
         issue(ops[i][15:8], ops[i][7:0]);
         repeat (3) begin
            seen = seen | (unsupported_op === 1'b1);
            req = req | (mem_req === 1'b1);
            tick();
         end
         check({31'h0, seen}, (i < 6) ? 32'h1 : 32'h0);
         check({31'h0, req}, 32'h0);
      end
      $display("test_unsupported finished");
   endtask : test_unsupported

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      instr_valid = 1'b0;
      instr = 16'h0000;
      reg_wr_en = 1'b0;
      reg_wr_sp = 1'b0;
      reg_wdata = 32'h0000_0000;
      mem_ack = 1'b0;
      mem_rdata = 32'h0000_0000;
      mismatches = 0;
      total_checks = 0;
      test_reset();
      test_word_direct();
      test_ptr_moves();
      test_narrow_direct();
      test_stack();
      test_unsupported();
      report_and_stop();
   end
endmodule : direct_address_move_decoder_test

// ### src/direct_address_move_decoder.sv
// Purpose: decode and run the direct-address move instructions
// Assumes: memory answers each request with a one-cycle mem_ack
// Notes:   one instruction in flight; instr_ready low while busy
// Notes on behaviour
// RULE1: opcode 08 loads direct word into pointer
// RULE2: opcode 18 stores pointer word to direct
// RULE3: 0C copies direct word to pointer, +4
// RULE4: 1C copies pointer word to direct, +4
// RULE5: 0B decrements stack by 4, then transfers
// RULE6: 1B pops stack word to direct, +4
// RULE7: 09/19 load/store pointer halfword
// RULE8: 0D/1D halfword pointer moves, pointer +2
// RULE9: 0A/1A load/store pointer byte
// RULE10: 0E/1E byte pointer moves, pointer +1
// RULE11: direct field scaled 1, 2, 4 by size
// RULE12: direct field zero-extended before scaling
// RULE13: resource opcodes BC/BD flagged unsupported
// RULE14: coprocessor opcodes 9F-C..9F-F flagged unsupported
// RULE15: upper byte opcode, lower byte direct field
`timescale 1ns/1ps
`include "direct_move_cfg.svh"

module direct_address_move_decoder (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // instruction in
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr,
   output logic             instr_ready,
   // core access to the pointers
   input  wire logic        reg_wr_en,
   input  wire logic        reg_wr_sp,
   input  wire logic [31:0] reg_wdata,
   // memory port
   output logic             mem_req,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [1:0]       mem_size,
   output logic [31:0]      mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   // state and status
   output logic [31:0]      direct_pointer_reg,
   output logic [31:0]      stack_pointer_reg,
   output logic             done,
   output logic             unsupported_op,
   output logic [1:0]       cycle_class
);

   direct_move_pkg::move_state_t state;
   direct_move_pkg::move_state_t next_state;

   logic [7:0]  opc;
   logic [7:0]  fld;
   logic        take;
   logic        is_move;
   logic        to_dir;
   logic        grp_reg;
   logic        grp_ptr;
   logic        grp_stack;
   logic [1:0]  dsize;
   logic [31:0] eff;
   logic [31:0] step;
   logic        coproc;

   // latched per instruction
   logic        cur_load_dp;
   logic        cur_to_dp_ptr;
   logic        cur_to_sp_ptr;
   logic [31:0] cur_step;
   logic [31:0] wr_addr;
   logic [1:0]  cur_size;

   assign opc  = instr[15:8]; // RULE15
   assign fld  = instr[7:0];  // RULE15
   assign take = instr_valid && instr_ready;

   // 08..0E and 18..1E, excluding x7 and xF
   assign is_move   = (opc[7:5] == 3'h0) && opc[3] && (opc[2:0] != 3'h7);
   assign to_dir    = opc[4];
   assign grp_reg   = (opc[3:0] == 4'h8) || (opc[3:0] == 4'h9) || (opc[3:0] == 4'hA);
   assign grp_ptr   = (opc[3:0] == 4'hC) || (opc[3:0] == 4'hD) || (opc[3:0] == 4'hE);
   assign grp_stack = (opc[3:0] == 4'hB);
   assign coproc    = (opc == `OP_COPROC_GRP) && (fld[7:4] >= `COPROC_SUB_LO);

   always_comb begin
      if ((opc[3:0] == 4'h9) || (opc[3:0] == 4'hD)) begin
         dsize = direct_move_pkg::SZ_HALF;
      end else if ((opc[3:0] == 4'hA) || (opc[3:0] == 4'hE)) begin
         dsize = direct_move_pkg::SZ_BYTE;
      end else begin
         dsize = direct_move_pkg::SZ_WORD;
      end
   end

   // unsigned field, so direct space sits at the bottom of memory
   always_comb begin
      if (dsize == direct_move_pkg::SZ_BYTE) begin
         eff  = {24'h000000, fld};                            // RULE11 RULE12
         step = `STEP_BYTE;                                   // RULE10
      end else if (dsize == direct_move_pkg::SZ_HALF) begin
         eff  = {24'h000000, fld} << `SHIFT_HALF;             // RULE11 RULE12
         step = `STEP_HALF;                                   // RULE8
      end else begin
         eff  = {24'h000000, fld} << `SHIFT_WORD;             // RULE11 RULE12
         step = `STEP_WORD;                                   // RULE3 RULE4 RULE6
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         direct_move_pkg::ST_IDLE: begin
            if (take && is_move) begin
               if (to_dir && grp_reg) begin
                  next_state = direct_move_pkg::ST_WRITE; // RULE2 RULE7 RULE9
               end else begin
                  next_state = direct_move_pkg::ST_READ;
               end
            end
         end
         direct_move_pkg::ST_READ: begin
            if (mem_ack) begin
               if (cur_load_dp) begin
                  next_state = direct_move_pkg::ST_DONE;
               end else begin
                  next_state = direct_move_pkg::ST_WRITE;
               end
            end
         end
         direct_move_pkg::ST_WRITE: begin
            if (mem_ack) begin
               next_state = direct_move_pkg::ST_DONE;
            end
         end
         direct_move_pkg::ST_DONE: begin
            next_state = direct_move_pkg::ST_IDLE;
         end
         default: begin
            next_state = direct_move_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state       <= direct_move_pkg::ST_IDLE;
         instr_ready <= 1'b0;
      end else begin
         state       <= next_state;
         instr_ready <= (next_state == direct_move_pkg::ST_IDLE);
      end
   end

   // per-instruction plan
   always_ff @(posedge clk) begin
      if (rst) begin
         cur_load_dp   <= 1'b0;
         cur_to_dp_ptr <= 1'b0;
         cur_to_sp_ptr <= 1'b0;
         cur_step      <= 32'h0000_0000;
         wr_addr       <= 32'h0000_0000;
         cur_size      <= 2'h0;
      end else if (take && is_move) begin
         cur_load_dp   <= !to_dir && grp_reg;                 // RULE1 RULE7 RULE9
         cur_to_dp_ptr <= grp_ptr;
         cur_to_sp_ptr <= to_dir && grp_stack;
         cur_step      <= step;
         cur_size      <= dsize;
         if (grp_ptr && !to_dir) begin
            wr_addr <= direct_pointer_reg;                    // RULE3 RULE8 RULE10
         end else if (grp_stack && !to_dir) begin
            wr_addr <= stack_pointer_reg - `STEP_WORD;        // RULE5
         end else begin
            wr_addr <= eff;
         end
      end
   end

   // memory port, held until acknowledged
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_addr  <= 32'h0000_0000;
         mem_size  <= 2'h0;
         mem_wdata <= 32'h0000_0000;
      end else if (state == direct_move_pkg::ST_IDLE) begin
         if (take && is_move) begin
            mem_req  <= 1'b1;
            mem_size <= dsize;
            if (to_dir && grp_reg) begin
               mem_we    <= 1'b1;
               mem_addr  <= eff;
               mem_wdata <= direct_pointer_reg;               // RULE2 RULE7 RULE9
            end else if (to_dir && grp_ptr) begin
               mem_we   <= 1'b0;
               mem_addr <= direct_pointer_reg;                // RULE4 RULE8 RULE10
            end else if (to_dir && grp_stack) begin
               mem_we   <= 1'b0;
               mem_addr <= stack_pointer_reg;                 // RULE6
            end else begin
               mem_we   <= 1'b0;
               mem_addr <= eff;                               // RULE1 RULE3 RULE5
            end
         end
      end else if (state == direct_move_pkg::ST_READ) begin
         if (mem_ack) begin
            mem_req   <= !cur_load_dp;
            mem_we    <= !cur_load_dp;
            mem_addr  <= wr_addr;
            mem_wdata <= mem_rdata;
         end
      end else if (state == direct_move_pkg::ST_WRITE) begin
         if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
         end
      end
   end

   // pointers: core writes only while idle
   always_ff @(posedge clk) begin
      if (rst) begin
         direct_pointer_reg <= `DP_RESET;
         stack_pointer_reg  <= `SP_RESET;
      end else if (state == direct_move_pkg::ST_IDLE) begin
         if (take && is_move && grp_stack && !to_dir) begin
            stack_pointer_reg <= stack_pointer_reg - `STEP_WORD; // RULE5
         end else if (reg_wr_en && reg_wr_sp) begin
            stack_pointer_reg <= reg_wdata;
         end else if (reg_wr_en) begin
            direct_pointer_reg <= reg_wdata;
         end
      end else if ((state == direct_move_pkg::ST_READ) && mem_ack && cur_load_dp) begin
         // narrow loads are zero-extended into the pointer
         if (cur_size == direct_move_pkg::SZ_BYTE) begin
            direct_pointer_reg <= {24'h000000, mem_rdata[7:0]};  // RULE9
         end else if (cur_size == direct_move_pkg::SZ_HALF) begin
            direct_pointer_reg <= {16'h0000, mem_rdata[15:0]};   // RULE7
         end else begin
            direct_pointer_reg <= mem_rdata;                     // RULE1
         end
      end else if (state == direct_move_pkg::ST_DONE) begin
         if (cur_to_dp_ptr) begin
            direct_pointer_reg <= direct_pointer_reg + cur_step; // RULE3 RULE4 RULE8 RULE10
         end else if (cur_to_sp_ptr) begin
            stack_pointer_reg <= stack_pointer_reg + `STEP_WORD; // RULE6
         end
      end
   end

   // status pulses and cycle class
   always_ff @(posedge clk) begin
      if (rst) begin
         done           <= 1'b0;
         unsupported_op <= 1'b0;
         cycle_class    <= direct_move_pkg::CLS_NONE;
      end else begin
         done           <= (state == direct_move_pkg::ST_DONE);
         // no channel resources and no coprocessor: flag, do nothing
         unsupported_op <= take && ((opc == `OP_RES_LOAD) || (opc == `OP_RES_STORE) || coproc); // RULE13 RULE14
         if (take && is_move) begin
            if (!to_dir && grp_reg) begin
               cycle_class <= direct_move_pkg::CLS_B;         // RULE1 RULE7 RULE9
            end else begin
               cycle_class <= direct_move_pkg::CLS_A;         // RULE2 RULE3 RULE5
            end
         end
      end
   end

   req_held_a: assert property (@(posedge clk) disable iff (rst) // RULE3
      mem_req && !mem_ack && (state != direct_move_pkg::ST_DONE) |=> mem_req && $stable(mem_addr))
      else $error("memory request dropped before ack");

   push_dec_a: assert property (@(posedge clk) disable iff (rst) // RULE5
      take && (opc == `OP_WORD_PUSH) |=> stack_pointer_reg == $past(stack_pointer_reg) - `STEP_WORD)
      else $error("stack pointer not decremented by four");

   ptr_word_a: assert property (@(posedge clk) disable iff (rst) // RULE3
      (state == direct_move_pkg::ST_DONE) && cur_to_dp_ptr && (cur_size == direct_move_pkg::SZ_WORD)
      |=> direct_pointer_reg == $past(direct_pointer_reg) + `STEP_WORD)
      else $error("pointer not advanced by four");

   ptr_half_a: assert property (@(posedge clk) disable iff (rst) // RULE8
      (state == direct_move_pkg::ST_DONE) && cur_to_dp_ptr && (cur_size == direct_move_pkg::SZ_HALF)
      |=> direct_pointer_reg == $past(direct_pointer_reg) + `STEP_HALF)
      else $error("pointer not advanced by two");

   byte_addr_a: assert property (@(posedge clk) disable iff (rst) // RULE12
      take && ((opc == `OP_BYTE_LD_DP) || (opc == `OP_BYTE_ST_DP)) |=> mem_addr == {24'h000000, $past(fld)})
      else $error("byte direct address wrong");

   word_addr_a: assert property (@(posedge clk) disable iff (rst) // RULE11
      take && ((opc == `OP_WORD_LD_DP) || (opc == `OP_WORD_ST_DP)) |=> mem_addr == {22'h0, $past(fld), 2'h0})
      else $error("word direct address not scaled by four");

   store_dp_a: assert property (@(posedge clk) disable iff (rst) // RULE2
      take && (opc == `OP_WORD_ST_DP) |=> mem_req && mem_we && (mem_wdata == $past(direct_pointer_reg)))
      else $error("pointer store not issued");

   unsup_idle_a: assert property (@(posedge clk) disable iff (rst) // RULE13
      take && ((opc == `OP_RES_LOAD) || (opc == `OP_RES_STORE)) |=> unsupported_op && !mem_req)
      else $error("resource opcode not flagged");

   coproc_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE14
      take && coproc |=> unsupported_op && !mem_req && instr_ready)
      else $error("coprocessor opcode not flagged");

   load_class_a: assert property (@(posedge clk) disable iff (rst) // RULE1
      take && (opc == `OP_WORD_LD_DP) |=> (cycle_class == direct_move_pkg::CLS_B) && !mem_we)
      else $error("word load to pointer wrong class");

endmodule : direct_address_move_decoder

// ### src/direct_move_cfg.svh
// Purpose: constants for the direct-address move decoder
// Assumes: 16-bit instruction, opcode in the upper byte
// Notes:   included by its bare name
`ifndef DIRECT_MOVE_CFG_SVH
`define DIRECT_MOVE_CFG_SVH

// opcodes of the direct moves
`define OP_WORD_LD_DP   8'h08
`define OP_WORD_ST_DP   8'h18
`define OP_WORD_TO_PTR  8'h0C
`define OP_WORD_FROM_PTR 8'h1C
`define OP_WORD_PUSH    8'h0B
`define OP_WORD_POP     8'h1B
`define OP_HALF_LD_DP   8'h09
`define OP_HALF_ST_DP   8'h19
`define OP_HALF_TO_PTR  8'h0D
`define OP_HALF_FROM_PTR 8'h1D
`define OP_BYTE_LD_DP   8'h0A
`define OP_BYTE_ST_DP   8'h1A
`define OP_BYTE_TO_PTR  8'h0E
`define OP_BYTE_FROM_PTR 8'h1E

// opcodes with no hardware behind them
`define OP_RES_LOAD     8'hBC
`define OP_RES_STORE    8'hBD
`define OP_COPROC_GRP   8'h9F
`define COPROC_SUB_LO   4'hC

// pointer steps and field scaling
`define STEP_WORD       32'h0000_0004
`define STEP_HALF       32'h0000_0002
`define STEP_BYTE       32'h0000_0001
`define SHIFT_HALF      1
`define SHIFT_WORD      2

// reset values of the pointers
`define DP_RESET        32'h0000_0000
`define SP_RESET        32'h0000_0000

`endif

// ### src/direct_move_pkg.sv
// Purpose: types for the direct-address move decoder
// Assumes: nothing beyond the cfg header
// Notes:   no constants here; they live in the cfg header
package direct_move_pkg;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_READ  = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_DONE  = 4'b1000
   } move_state_t;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0,
      SZ_HALF = 2'h1,
      SZ_WORD = 2'h2
   } move_size_t;

   typedef enum logic [1:0] {
      CLS_NONE = 2'h0,
      CLS_A    = 2'h1,
      CLS_B    = 2'h2
   } cycle_class_t;

endpackage : direct_move_pkg
